// *** aoi_pkg.sv ***
// Summary of operation
// - checksum code 00 sends the status header with every sample.
// - checksum code 01 replaces the header with a checksum every 4 samples.
// - checksum code 10 replaces the header with a checksum every 16 samples.
// - both intervals use the 8-bit polynomial x^8 + x^2 + x + 1.
// - checksum kept per channel, covering that channel's conversion data only.
// - output clock is master clock divided by 8, 4, 2 for codes 00, 01, 10.
// - conversion data shift out serially on the divided output clock.
// - writing 1 to the memory test start bit launches the RAM self test.
// - status shows self test progress and outcome as separate bits.
// - status bit 0 stays high while the self test runs.
// - status bit 1 latches a pass; only reset clears it.
// - each sync pulse resets the filters; no data until settling elapses.
`default_nettype none

package aoi_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          ADDR_W         = 7;
  localparam int          REG_W          = 8;
  localparam logic [6:0]  OFS_IFACE      = 7'h07;
  localparam logic [6:0]  OFS_TEST       = 7'h08;
  localparam logic [6:0]  OFS_STATUS     = 7'h09;
  localparam logic [7:0]  RST_IFACE      = 8'h00;
  localparam logic [7:0]  RST_TEST       = 8'h00;
  localparam logic [7:0]  MASK_IFACE     = 8'h0f;
  localparam logic [7:0]  MASK_TEST      = 8'h01;
  localparam int          CRC_SEL_LSB    = 2;
  localparam int          DIV_LSB        = 0;
  localparam int          TEST_START_BIT = 0;
  localparam int          ST_ACTIVE_BIT  = 0;
  localparam int          ST_PASS_BIT    = 1;

  // ****************************************
  // field codes
  // ****************************************
  localparam logic [1:0]  CRC_NONE       = 2'h0;
  localparam logic [1:0]  CRC_EVERY4     = 2'h1;
  localparam logic [1:0]  CRC_EVERY16    = 2'h2;
  localparam logic [1:0]  DIV_8          = 2'h0;
  localparam logic [1:0]  DIV_4          = 2'h1;
  localparam logic [1:0]  DIV_2          = 2'h2;
  localparam logic [1:0]  DIV_1          = 2'h3;
  localparam int          INTERVAL4      = 4;
  localparam int          INTERVAL16     = 16;

  // ****************************************
  // frame and checksum
  // ****************************************
  localparam int          HDR_W          = 8;
  localparam int          DATA_W         = 24;
  localparam int          FRAME_W        = 32;
  localparam logic [7:0]  CRC_POLY       = 8'h07;
  localparam logic [7:0]  CRC_INIT       = 8'h00;

  // ****************************************
  // self test and timing
  // ****************************************
  localparam int          TEST_RAM_W     = 8;
  localparam logic [7:0]  TEST_PATTERN   = 8'ha5;
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          SETTLE_DEFAULT = 64;

  typedef enum logic [1:0] {
    TS_IDLE,
    TS_WRITE,
    TS_READ,
    TS_DONE
  } aoi_test_state_t;

endpackage : aoi_pkg

`default_nettype wire

// *** aoi_fifo.sv ***
`default_nettype none

module aoi_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  // handshake flags
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rptr];

  // storage
  always_ff @(posedge core_clk) begin
    if (clk_en && push) begin
      mem[wptr] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else if (clk_en) begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

endmodule : aoi_fifo

`default_nettype wire

// *** aoi_test_ram.sv ***
`default_nettype none

module aoi_test_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // clock
  input  wire logic                     core_clk,
  input  wire logic                     clk_en,
  // access port
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wdata,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write and registered read
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (wr_en) mem[addr] <= wdata;
      if (rd_en) rdata <= mem[addr];
    end
  end

endmodule : aoi_test_ram

`default_nettype wire

// *** aoi_output_iface.sv ***
`default_nettype none

module aoi_output_iface #(
  parameter int NUM_CH        = 8,
  parameter int FIFO_DEPTH    = 16,
  parameter int RAM_DEPTH     = 64,
  parameter int SETTLE_CYCLES = aoi_pkg::SETTLE_DEFAULT
) (
  // clock, reset, enable
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire logic                         clk_en,
  // register port
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [aoi_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [aoi_pkg::REG_W-1:0]    reg_wdata,
  output logic      [aoi_pkg::REG_W-1:0]    reg_rdata,
  // conversion results in
  input  wire logic                         sample_valid,
  output logic                              sample_ready,
  input  wire logic [$clog2(NUM_CH)-1:0]    sample_chan,
  input  wire logic [aoi_pkg::HDR_W-1:0]    sample_status,
  input  wire logic [aoi_pkg::DATA_W-1:0]   sample_data,
  // synchronization
  input  wire logic                         sync_pulse,
  output logic                              filter_reset,
  // serial data output
  output logic                              data_output_clock,
  output logic                              serial_data_lines,
  output logic                              frame_start
);

  import aoi_pkg::*;

  localparam int CH_W   = $clog2(NUM_CH);
  localparam int WORD_W = CH_W + HDR_W + DATA_W;
  localparam int AW     = $clog2(RAM_DEPTH);
  localparam int SC_W   = $clog2(SETTLE_CYCLES + 1);

  if (NUM_CH < 2 || RAM_DEPTH < 2 || RAM_DEPTH > 256 || SETTLE_CYCLES < 2) begin : g_chk
    $error("unsupported channel count, ram depth or settle count");
  end

  // ****************************************
  // checksum and test pattern helpers
  // ****************************************
  function automatic logic [7:0] aoi_crc8(input logic [7:0] crc_in, input logic [23:0] d);
    logic [7:0] c;
    c = crc_in;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : aoi_crc8

  function automatic logic [7:0] aoi_pattern(input logic [AW-1:0] a);
    return TEST_RAM_W'(a) ^ TEST_PATTERN;
  endfunction : aoi_pattern

  logic [7:0]        iface_cfg;
  logic [7:0]        test_ctl;
  logic [1:0]        crc_sel;
  logic [1:0]        div_sel;
  aoi_test_state_t   tstate;
  logic [AW-1:0]     t_addr;
  logic              t_fail;
  logic              t_pass;
  logic              chk_vld;
  logic [AW-1:0]     chk_addr;
  logic [7:0]        ram_rdata;
  logic              mismatch;
  logic              test_active;
  logic              test_start;
  logic              await_sync;
  logic [SC_W-1:0]   settle_cnt;
  logic              run_ok;

  assign crc_sel = iface_cfg[CRC_SEL_LSB +: 2];
  assign div_sel = iface_cfg[DIV_LSB +: 2];

  // ****************************************
  // register file
  // ****************************************
  assign test_start = reg_wr && (reg_addr == OFS_TEST) && reg_wdata[TEST_START_BIT]
                    && (tstate == TS_IDLE);

  // software writes, reserved bits kept at zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      iface_cfg <= RST_IFACE;
      test_ctl  <= RST_TEST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == OFS_IFACE) iface_cfg <= reg_wdata & MASK_IFACE;
      if (reg_addr == OFS_TEST) test_ctl <= reg_wdata & MASK_TEST;
    end
  end

  // registered read, unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        OFS_IFACE:  reg_rdata <= iface_cfg;
        OFS_TEST:   reg_rdata <= test_ctl;
        OFS_STATUS: reg_rdata <= {6'h00, t_pass, test_active};
        default:    reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // output clock divider
  // ****************************************
  logic [2:0] div_last;
  logic [2:0] ph;
  logic [2:0] next_ph;
  logic [2:0] half;
  logic       data_output_clock_q;
  logic       bypass;
  logic       bit_tick;

  // period minus one for each divider code
  always_comb begin
    unique case (div_sel)
      DIV_8:   div_last = 3'h7;
      DIV_4:   div_last = 3'h3;
      DIV_2:   div_last = 3'h1;
      default: div_last = 3'h0;
    endcase
  end

  assign bit_tick = (ph >= div_last);
  assign next_ph  = bit_tick ? 3'h0 : ph + 3'h1;
  assign half     = {1'b0, div_last[2:1]} + 3'h1;

  // phase counter, clock high in first half of each bit
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ph     <= 3'h7; // wraps at first edge, so the first period is whole
      data_output_clock_q <= 1'b0;
      bypass <= 1'b0;
    end else if (clk_en) begin
      ph     <= next_ph;
      data_output_clock_q <= (next_ph < half);
      bypass <= (div_sel == DIV_1);
    end
  end

  // undivided mode passes the master clock straight out
  assign data_output_clock = bypass ? core_clk : data_output_clock_q;

  // ****************************************
  // sample buffer
  // ****************************************
  logic              f_valid;
  logic              f_ready;
  logic [WORD_W-1:0] f_word;
  logic              in_ready;
  logic [CH_W-1:0]   f_chan;
  logic [7:0]        f_stat;
  logic [23:0]       f_data;

  assign sample_ready = in_ready && run_ok;
  assign {f_chan, f_stat, f_data} = f_word;

  aoi_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .in_valid  (sample_valid && run_ok),
    .in_ready  (in_ready),
    .in_data   ({sample_chan, sample_status, sample_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_word)
  );

  // ****************************************
  // per-channel checksum
  // ****************************************
  logic [7:0] crc_acc [NUM_CH];
  logic [3:0] crc_cnt [NUM_CH];
  logic [7:0] crc_new;
  logic [3:0] int_last;
  logic       crc_on;
  logic       send_crc;
  logic       load;
  logic [7:0] header;

  assign crc_on   = (crc_sel == CRC_EVERY4) || (crc_sel == CRC_EVERY16);
  assign int_last = (crc_sel == CRC_EVERY4) ? 4'(INTERVAL4 - 1) : 4'(INTERVAL16 - 1);
  assign crc_new  = aoi_crc8(crc_acc[f_chan], f_data);
  assign send_crc = crc_on && (crc_cnt[f_chan] >= int_last);
  assign header   = send_crc ? crc_new : f_stat;

  // accumulators restart on sync and after each checksum message
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int c = 0; c < NUM_CH; c++) begin
        crc_acc[c] <= CRC_INIT;
        crc_cnt[c] <= 4'h0;
      end
    end else if (clk_en) begin
      if (sync_pulse || !crc_on) begin
        for (int c = 0; c < NUM_CH; c++) begin
          crc_acc[c] <= CRC_INIT;
          crc_cnt[c] <= 4'h0;
        end
      end else if (load) begin
        crc_acc[f_chan] <= send_crc ? CRC_INIT : crc_new;
        crc_cnt[f_chan] <= send_crc ? 4'h0 : crc_cnt[f_chan] + 4'h1;
      end
    end
  end

  // ****************************************
  // serializer
  // ****************************************
  logic [31:0] shreg;
  logic [4:0]  bit_cnt;
  logic        busy;
  logic        frame_end;

  assign frame_end = busy && (bit_cnt == 5'(FRAME_W - 1));
  assign load      = bit_tick && (!busy || frame_end) && f_valid && run_ok;
  assign f_ready   = load;

  // header then data, msb first, one bit per output clock
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      shreg       <= 32'h0000_0000;
      bit_cnt     <= 5'h00;
      busy        <= 1'b0;
      frame_start <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        shreg       <= {header, f_data};
        bit_cnt     <= 5'h00;
        busy        <= 1'b1;
        frame_start <= 1'b1;
      end else if (bit_tick && busy) begin
        shreg       <= {shreg[30:0], 1'b0};
        bit_cnt     <= bit_cnt + 5'h01;
        frame_start <= 1'b0;
        if (frame_end) busy <= 1'b0;
      end
    end
  end

  assign serial_data_lines = shreg[31];

  // ****************************************
  // filter ram self test
  // ****************************************
  assign test_active = (tstate != TS_IDLE);
  assign mismatch    = chk_vld && (ram_rdata != aoi_pattern(chk_addr));

  aoi_test_ram #(
    .WIDTH (TEST_RAM_W),
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .core_clk (core_clk),
    .clk_en   (clk_en),
    .wr_en    (tstate == TS_WRITE),
    .rd_en    (tstate == TS_READ),
    .addr     (t_addr),
    .wdata    (aoi_pattern(t_addr)),
    .rdata    (ram_rdata)
  );

  // write pattern pass, read-compare pass, then latch result
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tstate   <= TS_IDLE;
      t_addr   <= '0;
      t_fail   <= 1'b0;
      t_pass   <= 1'b0;
      chk_vld  <= 1'b0;
      chk_addr <= '0;
    end else if (clk_en) begin
      chk_vld  <= (tstate == TS_READ);
      chk_addr <= t_addr;
      if (mismatch) t_fail <= 1'b1;
      unique case (tstate)
        TS_IDLE: begin
          if (test_start) begin
            tstate <= TS_WRITE;
            t_addr <= '0;
            t_fail <= 1'b0;
          end
        end
        TS_WRITE: begin
          t_addr <= t_addr + 1'b1;
          if (t_addr == AW'(RAM_DEPTH - 1)) tstate <= TS_READ;
        end
        TS_READ: begin
          t_addr <= t_addr + 1'b1;
          if (t_addr == AW'(RAM_DEPTH - 1)) tstate <= TS_DONE;
        end
        TS_DONE: begin
          tstate <= TS_IDLE;
          if (!t_fail && !mismatch) t_pass <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // sync and settling gate
  // ****************************************
  assign run_ok = !test_active && !await_sync && (settle_cnt == '0);

  // end of test waits for sync; sync restarts the settle count
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      await_sync   <= 1'b0;
      settle_cnt   <= '0;
      filter_reset <= 1'b0;
    end else if (clk_en) begin
      filter_reset <= sync_pulse;
      if (tstate == TS_DONE) await_sync <= 1'b1;
      else if (sync_pulse) await_sync <= 1'b0;
      if (sync_pulse) settle_cnt <= SC_W'(SETTLE_CYCLES);
      else if (settle_cnt != '0) settle_cnt <= settle_cnt - 1'b1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_plain_header: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    load && (crc_sel == CRC_NONE) |=> shreg[31:24] == $past(f_stat))
    else $error("status header not sent with checksum off");

  a_crc_every4: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    load && (crc_sel == CRC_EVERY4) && (crc_cnt[f_chan] == 4'h3) |-> send_crc)
    else $error("checksum missing on fourth sample");

  a_crc_every16: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    load && (crc_sel == CRC_EVERY16) |-> send_crc == (crc_cnt[f_chan] == 4'hf))
    else $error("checksum misplaced in sixteen-sample mode");

  a_crc_header: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    load && send_crc |=> shreg[31:24] == $past(crc_new) && shreg[23:0] == $past(f_data))
    else $error("checksum header does not carry computed value");

  a_crc_restart: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    load && send_crc && !sync_pulse |=> crc_acc[$past(f_chan)] == CRC_INIT)
    else $error("channel checksum not restarted after message");

  a_div8_shape: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    $rose(data_output_clock_q) ##0 (div_sel == DIV_8)[*8]
      |-> !data_output_clock_q && !$past(data_output_clock_q, 3) && $past(data_output_clock_q, 4))
    else $error("divide by eight clock shape wrong");

  a_bit_hold: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    busy && !bit_tick |=> $stable(serial_data_lines))
    else $error("data line changed between output clock bits");

  a_test_blocks: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    test_active |-> !sample_ready && !load)
    else $error("conversion data flowing during self test");

  a_active_flag: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    test_start |=> test_active [*2])
    else $error("running flag not raised by start");

  a_pass_sticky: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    t_pass |=> t_pass)
    else $error("pass flag cleared without reset");

  a_settle_gate: assert property (@(posedge core_clk) disable iff (!resetn || !clk_en)
    sync_pulse |=> !load [*2])
    else $error("data output before filter settling");

  c_crc_sent:  cover property (@(posedge core_clk) disable iff (!resetn) load && send_crc);
  c_test_pass: cover property (@(posedge core_clk) disable iff (!resetn) $rose(t_pass));
  c_div2_load: cover property (@(posedge core_clk) disable iff (!resetn)
    load && (div_sel == DIV_2));
  c_resume:    cover property (@(posedge core_clk) disable iff (!resetn)
    $fell(await_sync) ##[1:200] load);

endmodule : aoi_output_iface

`default_nettype wire

// *** aoi_host_model.sv ***
`default_nettype none

// ****************************************
// host side receiver of the serial frames
// ****************************************
module aoi_host_model (
  // serial data output of the device
  input  wire logic data_output_clock,
  input  wire logic serial_data_lines,
  input  wire logic frame_start
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] frames [$];
  logic [31:0] shreg   = 32'h0;
  logic        pend    = 1'b0;
  int          cnt     = 0;

  // a frame marker arms capture at the next bit sample
  always @(posedge frame_start) pend = 1'b1;

  // sample each bit on the falling output clock edge, msb first
  always @(negedge data_output_clock) begin
    if (pend) begin
      shreg = {31'h0, serial_data_lines};
      cnt = 1;
      pend = 1'b0;
    end else if (cnt > 0) begin
      shreg = {shreg[30:0], serial_data_lines};
      cnt++;
    end
    if (cnt == 32) begin
      frames.push_back(shreg);
      cnt = 0;
    end
  end
endmodule : aoi_host_model

`default_nettype wire

// *** adc_output_iface_and_ram_self_test_test.sv ***
`default_nettype none

module adc_output_iface_and_ram_self_test_test;
  import aoi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [1:0] crc; logic [1:0] dv; int n; int per;} aoi_row_t;
  aoi_row_t rows [4] = '{'{CRC_NONE, DIV_8, 3, 8}, '{CRC_EVERY4, DIV_4, 8, 4},
                         '{CRC_EVERY16, DIV_2, 20, 2}, '{2'h3, DIV_1, 4, 1}};

  logic        core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, sample_status = 8'h00, v;
  logic        sample_valid = 1'b0, sample_ready, sync_pulse = 1'b0, filter_reset;
  logic [2:0]  sample_chan = 3'h0;
  logic [23:0] sample_data = 24'h0;
  logic        data_output_clock, serial_data_lines, frame_start;
  logic [31:0] expq [$];
  logic [7:0]  acc [2], hdr;
  int          error_cnt = 0, samples_checked = 0, k [2], iv, ch;
  realtime     t0;

  always #10 core_clk = ~core_clk;

  aoi_output_iface #(.RAM_DEPTH(8), .SETTLE_CYCLES(4)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .clk_en(1'b1), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_chan(sample_chan),
    .sample_status(sample_status), .sample_data(sample_data), .sync_pulse(sync_pulse),
    .filter_reset(filter_reset), .data_output_clock(data_output_clock),
    .serial_data_lines(serial_data_lines), .frame_start(frame_start));

  aoi_host_model u_host (.data_output_clock(data_output_clock),
    .serial_data_lines(serial_data_lines), .frame_start(frame_start));

  // ****************************************
  // compare, bus and stimulus tasks
  // ****************************************
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_reg

  task automatic chk_frame(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_frame

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge core_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  task automatic sync;
    @(negedge core_clk);
    sync_pulse = 1'b1;
    @(negedge core_clk);
    sync_pulse = 1'b0;
    chk_reg({7'h0, filter_reset}, 8'h01);
    repeat (10) @(negedge core_clk);
  endtask : sync

  task automatic send(input logic [7:0] st, input logic [23:0] d);
    @(negedge core_clk);
    {sample_valid, sample_status, sample_data} = {1'b1, st, d};
    for (int w = 0; w < 300 && !sample_ready; w++) @(negedge core_clk);
    @(negedge core_clk);
    sample_valid = 1'b0;
  endtask : send

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [23:0] d);
    logic fb;
    for (int b = 23; b >= 0; b--) begin
      fb = c[7] ^ d[b];
      c = {c[6:0], 1'b0};
      if (fb) c ^= CRC_POLY;
    end
    return c;
  endfunction : crc_step

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    for (int a = 7; a <= 9; a++) begin
      rd(7'(a), v);
      chk_reg(v, 8'h00);
    end
    wr(OFS_IFACE, 8'hff);
    rd(OFS_IFACE, v);
    chk_reg(v, 8'h0f);
    wr(7'h30, 8'hff);
    rd(7'h30, v);
    chk_reg(v, 8'h00);
    wr(OFS_STATUS, 8'hff);
    rd(OFS_STATUS, v);
    chk_reg(v, 8'h00);
    // table of checksum and divider settings
    foreach (rows[r]) begin
      wr(OFS_IFACE, {4'h0, rows[r].crc, rows[r].dv});
      sync();
      u_host.frames.delete();
      expq.delete();
      acc = '{CRC_INIT, CRC_INIT};
      k = '{0, 0};
      iv = rows[r].crc == CRC_EVERY4 ? 4 : rows[r].crc == CRC_EVERY16 ? 16 : 0;
      for (int i = 0; i < rows[r].n; i++) begin
        // the every-4 row interleaves two channels, each with its own checksum
        ch = (r == 1) ? i % 2 : 0;
        sample_chan = 3'(ch);
        sample_data = {4'(r), 20'(i * 20'h1357b)};
        acc[ch] = crc_step(acc[ch], sample_data);
        k[ch]++;
        hdr = (iv != 0 && k[ch] == iv) ? acc[ch] : 8'(16 * r + i);
        if (iv != 0 && k[ch] == iv) begin
          acc[ch] = CRC_INIT;
          k[ch] = 0;
        end
        expq.push_back({hdr, sample_data});
        send(8'(16 * r + i), sample_data);
      end
      @(posedge data_output_clock) t0 = $realtime;
      @(posedge data_output_clock);
      chk_reg(8'(int'(($realtime - t0) / 20.0)), 8'(rows[r].per));
      for (int w = 0; w < 5000 && u_host.frames.size() < rows[r].n; w++) @(negedge core_clk);
      chk_reg(8'(u_host.frames.size()), 8'(rows[r].n));
      foreach (expq[i])
        if (i < u_host.frames.size()) chk_frame(u_host.frames[i], expq[i]);
    end
    // memory self test, then resume by sync
    wr(OFS_TEST, 8'h01);
    repeat (2) @(negedge core_clk);
    rd(OFS_STATUS, v);
    chk_reg(v, 8'h01);
    chk_reg({7'h0, sample_ready}, 8'h00);
    for (int w = 0; w < 100 && v[ST_ACTIVE_BIT] === 1'b1; w++) rd(OFS_STATUS, v);
    chk_reg(v, 8'h02);
    repeat (20) @(negedge core_clk);
    chk_reg({7'h0, sample_ready}, 8'h00);
    sync();
    chk_reg({7'h0, sample_ready}, 8'h01);
    // conversion data flows again after the sync
    u_host.frames.delete();
    send(8'h5a, 24'h0abcde);
    for (int w = 0; w < 300 && u_host.frames.size() == 0; w++) @(negedge core_clk);
    chk_frame(u_host.frames[0], 32'h5a0abcde);
    rd(OFS_TEST, v);
    chk_reg(v, 8'h01);
    resetn = 1'b0;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    rd(OFS_STATUS, v);
    chk_reg(v, 8'h00);
    tally_and_finish();
  end
endmodule : adc_output_iface_and_ram_self_test_test

`default_nettype wire
